// ---- hdl/ldorc_pkg.sv ----
package ldorc_pkg;

	// ************************************************************
	// Special function register map
	// ************************************************************
	localparam logic [7:0] REGULATOR_CONTROL_ADDR = 8'hc9;
	localparam logic [7:0] REGULATOR_CONTROL_PAGE = 8'h00;
	localparam logic [7:0] REGULATOR_CONTROL_RST  = 8'h50;

	// ************************************************************
	// Field positions of regulator_control
	// ************************************************************
	localparam int REGULATOR_OFF_BIT       = 7;
	localparam int RESERVED_ONE_BIT        = 6;
	localparam int OUTPUT_LEVEL_SELECT_BIT = 4;
	localparam int DROPOUT_BIT             = 0;

	// Lanes with no function: bits 5 and 3:1
	localparam logic [7:0] UNUSED_LANES_MASK = 8'h2e;

	// Flops between the dropout comparator and its status bit
	localparam int DROPOUT_SYNC_STAGES = 2;

	// Values after reset
	localparam logic REGULATOR_OFF_RST       = 1'b0;
	localparam logic OUTPUT_LEVEL_SELECT_RST = 1'b1;
	localparam logic RESERVED_ONE_VALUE      = 1'b1;
	localparam logic DROPOUT_SYNC_RST        = 1'b0;
	localparam logic IRQ_RST                 = 1'b0;
	localparam logic PRIORITY_RST            = 1'b0;
	localparam logic RVALID_RST              = 1'b0;
	localparam logic [7:0] RDATA_IDLE        = 8'h00;

	// Output level codes: 0 gives 2.1V, 1 gives 2.6V
	localparam logic LEVEL_2V1 = 1'b0;
	localparam logic LEVEL_2V6 = 1'b1;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] page;
		logic       write;
		logic       read;
		logic [7:0] wdata;
	} ldorc_sfr_req_s;

	typedef struct packed {
		logic [7:0] rdata;
		logic       rvalid;
	} ldorc_sfr_rsp_s;

	typedef struct packed {
		logic           regulatorOff;
		logic           outputLevelSelect;
		logic           dropoutMeta;
		logic           dropoutSync;
		logic           supplySagIrq;
		logic           supplySagIrqPriority;
		ldorc_sfr_rsp_s rsp;
	} ldorc_state_s;

endpackage

// ---- hdl/ldorc_regulator_control.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Regulator comes up enabled after reset; stays enabled until software disables it.
// - Bit 7 is read/write disable: zero keeps regulator on, one turns it off.
// - Bit 4 selects output level: zero 2.1V, one 2.6V; resets to one.
// - Reserved bit 6 reads as one; software always writes one there.
// - Bits 5 and 3:1 read zero; writes to them are ignored.
// - Bit 0 reports dropout state, set by hardware; writes have no effect.
// - Dropout interrupt request raised only while its enable bit is set.
// - No pending flag; request follows live condition, no software acknowledge.
// - Dropout interrupt priority comes from its dedicated priority bit.
// - Register decodes at address 0xc9 only when page 0x00 is selected.
module ldorc_regulator_control #(
	// Register geometry, fixed by the carriers
	parameter int DATA_WIDTH  = 8,
	parameter int ADDR_WIDTH  = 8,
	parameter int PAGE_WIDTH  = 8,
	// Depth of the dropout synchroniser
	parameter int SYNC_STAGES = ldorc_pkg::DROPOUT_SYNC_STAGES
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset,
	// Special function register access
	input  wire ldorc_pkg::ldorc_sfr_req_s sfrReq,
	output var  ldorc_pkg::ldorc_sfr_rsp_s sfrRsp,
	// Interrupt controller bits
	input  wire logic                     supplySagIrqEnable,
	input  wire logic                     supplySagIrqPriorityIn,
	// Analog regulator
	input  wire logic                     dropoutRaw,
	output logic                          regulatorOff,
	output logic                          outputLevelSelect,
	// Interrupt request
	output logic                          supplySagIrq,
	output logic                          supplySagIrqPriority
);
	import ldorc_pkg::*;

	ldorc_state_s state_reg;
	ldorc_state_s state_next;
	logic         regHit;
	logic [7:0]   readValue;
	logic         hitRead;
	logic         hitWrite;
	logic [7:0]   laneWrite;

	// ************************************************************
	// Lane classes of regulator_control
	// ************************************************************
	localparam logic [7:0] STORED_LANES    = (8'h01 << REGULATOR_OFF_BIT)
		| (8'h01 << OUTPUT_LEVEL_SELECT_BIT);
	localparam logic [7:0] FIXED_ONE_LANES = 8'h01 << RESERVED_ONE_BIT;
	localparam logic [7:0] LIVE_LANES      = 8'h01 << DROPOUT_BIT;
	localparam logic [7:0] NAMED_LANES     = STORED_LANES | FIXED_ONE_LANES | LIVE_LANES;
	// Rebuilt from the field constants so the package cannot drift apart
	localparam logic [7:0] RESET_IMAGE     = (8'(REGULATOR_OFF_RST) << REGULATOR_OFF_BIT)
		| (8'(OUTPUT_LEVEL_SELECT_RST) << OUTPUT_LEVEL_SELECT_BIT)
		| (8'(RESERVED_ONE_VALUE) << RESERVED_ONE_BIT);

	// ************************************************************
	// Value after reset
	// ************************************************************
	localparam ldorc_state_s STATE_RST = '{
		regulatorOff:         REGULATOR_OFF_RST,
		outputLevelSelect:    OUTPUT_LEVEL_SELECT_RST,
		dropoutMeta:          DROPOUT_SYNC_RST,
		dropoutSync:          DROPOUT_SYNC_RST,
		supplySagIrq:         IRQ_RST,
		supplySagIrqPriority: PRIORITY_RST,
		rsp:                  '{rdata: RDATA_IDLE, rvalid: RVALID_RST}
	};

	// ************************************************************
	// Address and page decode
	// ************************************************************
	always_comb begin
		regHit = (sfrReq.addr == REGULATOR_CONTROL_ADDR)
			&& (sfrReq.page == REGULATOR_CONTROL_PAGE);
		hitRead = sfrReq.read && regHit;
		hitWrite = sfrReq.write && regHit;
	end

	// ************************************************************
	// Per-lane write acceptance and read value
	// ************************************************************
	// Only stored lanes take write data; the rest ignore it silently
	for (genvar lane = 0; lane < DATA_WIDTH; lane++) begin : g_lane
		if (STORED_LANES[lane]) begin : g_stored
			assign laneWrite[lane] = hitWrite;
		end else begin : g_ignored
			assign laneWrite[lane] = 1'b0;
		end
		if (lane == REGULATOR_OFF_BIT) begin : g_off
			assign readValue[lane] = state_reg.regulatorOff;
		end else if (lane == OUTPUT_LEVEL_SELECT_BIT) begin : g_level
			assign readValue[lane] = state_reg.outputLevelSelect;
		end else if (LIVE_LANES[lane]) begin : g_live
			assign readValue[lane] = state_reg.dropoutSync;
		end else if (FIXED_ONE_LANES[lane]) begin : g_fixed
			assign readValue[lane] = RESERVED_ONE_VALUE;
		end else begin : g_unused
			assign readValue[lane] = 1'b0;
		end
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		// Analog flag is asynchronous to clk, so it passes two flops first
		state_next.dropoutMeta = dropoutRaw;
		state_next.dropoutSync = state_reg.dropoutMeta;

		// Only bits 7 and 4 are stored; all other lanes are dropped
		if (laneWrite[REGULATOR_OFF_BIT]) begin
			state_next.regulatorOff = sfrReq.wdata[REGULATOR_OFF_BIT];
		end
		if (laneWrite[OUTPUT_LEVEL_SELECT_BIT]) begin
			state_next.outputLevelSelect = sfrReq.wdata[OUTPUT_LEVEL_SELECT_BIT];
		end

		// Live level, no latch: it drops when dropoutSync falls or the enable is masked
		state_next.supplySagIrq = state_reg.dropoutSync && supplySagIrqEnable;
		state_next.supplySagIrqPriority = supplySagIrqPriorityIn;

		// Read data is zero when idle so a bus OR of many slaves stays clean
		state_next.rsp.rvalid = hitRead;
		state_next.rsp.rdata = hitRead ? readValue : RDATA_IDLE;
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= STATE_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// Outputs, each straight from a flop
	// ************************************************************
	assign sfrRsp = state_reg.rsp;
	assign regulatorOff = state_reg.regulatorOff;
	assign outputLevelSelect = state_reg.outputLevelSelect;
	assign supplySagIrq = state_reg.supplySagIrq;
	assign supplySagIrqPriority = state_reg.supplySagIrqPriority;

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	// Carriers fix a byte-wide bus; another width needs new structs
	if (DATA_WIDTH != 8) begin : g_bad_data_width
		$error("ldorc_regulator_control: DATA_WIDTH must be 8");
	end

	if (ADDR_WIDTH != 8) begin : g_bad_addr_width
		$error("ldorc_regulator_control: ADDR_WIDTH must be 8");
	end

	if (PAGE_WIDTH != 8) begin : g_bad_page_width
		$error("ldorc_regulator_control: PAGE_WIDTH must be 8");
	end

	// The state struct holds exactly two synchroniser flops
	if (SYNC_STAGES != DROPOUT_SYNC_STAGES) begin : g_bad_sync_stages
		$error("ldorc_regulator_control: SYNC_STAGES must be 2");
	end

	// Every named lane must sit inside the byte
	if (REGULATOR_OFF_BIT >= DATA_WIDTH) begin : g_bad_off_lane
		$error("ldorc_regulator_control: disable lane outside the byte");
	end

	if (RESERVED_ONE_BIT >= DATA_WIDTH) begin : g_bad_fixed_lane
		$error("ldorc_regulator_control: reserved lane outside the byte");
	end

	if (OUTPUT_LEVEL_SELECT_BIT >= DATA_WIDTH) begin : g_bad_level_lane
		$error("ldorc_regulator_control: level lane outside the byte");
	end

	if (DROPOUT_BIT >= DATA_WIDTH) begin : g_bad_live_lane
		$error("ldorc_regulator_control: dropout lane outside the byte");
	end

	// Two fields on one lane would make the read mux ambiguous
	if ($countones(NAMED_LANES) != 4) begin : g_bad_lane_overlap
		$error("ldorc_regulator_control: named lanes overlap");
	end

	// Named and unused lanes together cover the byte exactly once
	if (NAMED_LANES != ~UNUSED_LANES_MASK) begin : g_bad_unused_lanes
		$error("ldorc_regulator_control: unused lane mask disagrees");
	end

	// Field reset constants must add up to the register's reset value
	if (RESET_IMAGE != REGULATOR_CONTROL_RST) begin : g_bad_reset_image
		$error("ldorc_regulator_control: field resets disagree");
	end

	// The reserved lane must read back as one
	if (RESERVED_ONE_VALUE != 1'b1) begin : g_bad_reserved_value
		$error("ldorc_regulator_control: reserved lane must read one");
	end

endmodule

`default_nettype wire

// ---- sim/ldorc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ldorc_checker (
	input wire logic clk, reset,
	input wire ldorc_pkg::ldorc_sfr_req_s sfrReq,
	input wire ldorc_pkg::ldorc_sfr_rsp_s sfrRsp,
	input wire logic supplySagIrqEnable, supplySagIrqPriorityIn, dropoutRaw,
	input wire logic regulatorOff, outputLevelSelect, supplySagIrq, supplySagIrqPriority
);
	import ldorc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire hit = sfrReq.addr == REGULATOR_CONTROL_ADDR && sfrReq.page == REGULATOR_CONTROL_PAGE;
	wire rd = hit && sfrReq.read;
	wire wr = hit && sfrReq.write;
	wire [7:0] wd = sfrReq.wdata;
	// Two sync flops and the flop behind them must have left reset: three cycles
	sequence s_up; (!reset) [*3]; endsequence
	property p_wr; wr |=> regulatorOff == $past(wd[7]) && outputLevelSelect == $past(wd[4]); endproperty
	a_wr: assert property (p_wr) else $error("bad write");
	property p_rd; rd |=> sfrRsp.rvalid && sfrRsp.rdata[7:1] ==
		{$past(regulatorOff), 2'b10, $past(outputLevelSelect), 3'b0}; endproperty
	a_rd: assert property (p_rd) else $error("bad read");
	property p_no; !rd |=> sfrRsp == '0; endproperty
	a_no: assert property (p_no) else $error("bad decode");
	property p_dr; s_up ##0 rd |=> sfrRsp.rdata[0] == $past(dropoutRaw, 3); endproperty
	a_dr: assert property (p_dr) else $error("bad dropout");
	property p_ir; s_up ##1 1 |-> supplySagIrq == ($past(dropoutRaw, 3) && $past(supplySagIrqEnable));
	endproperty
	a_ir: assert property (p_ir) else $error("bad irq");
	property p_pr; !$past(reset) |-> supplySagIrqPriority == $past(supplySagIrqPriorityIn); endproperty
	a_pr: assert property (p_pr) else $error("bad priority");
	property p_hd; !wr |=> $stable({regulatorOff, outputLevelSelect}); endproperty
	a_hd: assert property (p_hd) else $error("bad hold");
	property p_rs; disable iff (1'b0) reset |=> !regulatorOff && outputLevelSelect && !supplySagIrq;
	endproperty
	a_rs: assert property (p_rs) else $error("bad reset");
endmodule
bind ldorc_regulator_control ldorc_checker i_ldorc_checker (.clk, .reset, .sfrReq, .sfrRsp,
	.supplySagIrqEnable, .supplySagIrqPriorityIn, .dropoutRaw, .regulatorOff, .outputLevelSelect,
	.supplySagIrq, .supplySagIrqPriority);
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ldorc_pkg::*;
	logic clk = 0, reset = 1, en = 0, pri = 0, raw = 0, off, lvl, irq, prio, o, l;
	ldorc_sfr_req_s req = '0;
	ldorc_sfr_rsp_s rsp;
	integer seed = 32'hfaa7, error_cnt = 0, n_tests = 0, i;
	logic [31:0] r;
	always #2 clk = ~clk;
	ldorc_regulator_control i_ldorc_regulator_control (.clk, .reset, .sfrReq(req), .sfrRsp(rsp),
		.supplySagIrqEnable(en), .supplySagIrqPriorityIn(pri), .dropoutRaw(raw),
		.regulatorOff(off), .outputLevelSelect(lvl), .supplySagIrq(irq), .supplySagIrqPriority(prio));
	function logic [12:0] want(input logic o, l, d, e, q);
		return {o, 2'b10, l, 3'b0, d, 1'b1, o, l, d & e, q};
	endfunction
	task acc(input logic w, input logic [7:0] a, p, d);
		@(posedge clk) req <= '{a, p, w, !w, d};
		@(posedge clk) req <= '0;
		#1;
	endtask
	task results;
		$display("errors %0d tests %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#40000 error_cnt++;
		results;
	end
	initial begin
		o = 0;
		l = 1;
		repeat (5) @(posedge clk);
		reset <= 0;
		for (i = 0; i < 300; i++) begin
			r = i == 0 ? 32'h0 : i == 1 ? 32'hff00000f : i == 2 ? 32'hb : $random(seed);
			if (i == 150) begin
				@(posedge clk) reset <= 1;
				@(posedge clk) reset <= 0;
				{o, l} = {REGULATOR_OFF_RST, OUTPUT_LEVEL_SELECT_RST};
			end
			@(posedge clk) {pri, en, raw} <= r[4:2];
			// Misses use an odd page or an even address so they never alias the hit
			acc(1, r[0] ? 8'hc9 : {r[15:9], 1'b0}, r[1] ? 8'h00 : r[23:16] | 8'h01, r[31:24] | 8'h40);
			if (r[1:0] == 2'b11) {o, l} = {r[31], r[28]};
			acc(0, 8'hc9, 8'h00, 8'h00);
			n_tests++;
			if ({rsp, off, lvl, irq, prio} !== want(o, l, raw, en, pri)) begin
				error_cnt++;
				$display("BAD state exp %h got %h", want(o, l, raw, en, pri), {rsp, off, lvl, irq, prio});
			end
		end
		results;
	end
endmodule
`default_nettype wire
